// file: pkg/pced_regs.svh
`ifndef PCED_REGS_SVH
`define PCED_REGS_SVH

// Register indices on the plain register port
`define PCED_ADDR_PA_RISE 4'h0
`define PCED_ADDR_PA_FALL 4'h1
`define PCED_ADDR_PA_FLAG 4'h2
`define PCED_ADDR_PB_RISE 4'h3
`define PCED_ADDR_PB_FALL 4'h4
`define PCED_ADDR_PB_FLAG 4'h5
`define PCED_ADDR_CTRL 4'h6
`define PCED_ADDR_IRQ_STAT 4'h7
`define PCED_ADDR_IRQ_MASK 4'h8

// Implemented bit masks
`define PCED_PA_MASK 8'h3F
`define PCED_PB_MASK 8'hF0
`define PCED_RESET_BYTE 8'h00

// Control register fields
`define PCED_CTRL_MASTER_BIT 3
`define PCED_CTRL_SUMMARY_BIT 0

// Interrupt status bits
`define PCED_IRQ_CHANGE_BIT 0
`define PCED_IRQ_WAKE_BIT 1
`define PCED_IRQ_MASK_BITS 8'h03

`endif

// file: pkg/pced_pkg.sv
package pced_pkg;
  typedef logic [7:0] pced_byte_t;
  typedef logic [3:0] pced_addr_t;
endpackage

// file: logic/pced_edge_sync.sv
`timescale 1ns/100ps
module pced_edge_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pins in, edges out
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] rise_pulse,
  output logic [WIDTH-1:0] fall_pulse
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } pced_sync_s;

  pced_sync_s state_reg;
  pced_sync_s state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.meta = pin_async;
    state_next.sync = state_reg.meta;
    state_next.last = state_reg.sync;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // One pulse per edge: compare with previous sample
  assign rise_pulse = state_reg.sync & ~state_reg.last; // RQ11
  assign fall_pulse = ~state_reg.sync & state_reg.last; // RQ11
endmodule

// file: logic/pced_pin_change.sv
// Behaviour
// RQ1: Per-pin falling edge enable, upper port B
// RQ2: Armed edge sets pin flag and summary
// RQ3: Flag sets on enabled rise or fall
// RQ4: Hardware sets flags; software writes zero clear
// RQ5: Port B low nibble reads zero, ignores writes
// RQ6: All enables and flags reset to zero
// RQ7: Port A six pins behave likewise
// RQ8: Detection runs regardless of master enable
// RQ9: Edge during clear write keeps flag set
// RQ10: Enabled edge raises wake request when enabled
// RQ11: Synchronise pins, one flag per edge
`timescale 1ns/100ps
`include "pced_regs.svh"
module pced_pin_change (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire pced_pkg::pced_addr_t reg_addr,
  input wire pced_pkg::pced_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output pced_pkg::pced_byte_t reg_rdata,
  // Port pins
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  // Processor side
  input wire logic sleep_active,
  output logic change_irq_summary,
  output logic change_irq_request,
  output logic wake_request,
  output logic irq
);
  import pced_pkg::*;

  typedef struct packed {
    pced_byte_t pa_rise;
    pced_byte_t pa_fall;
    pced_byte_t pa_flag;
    pced_byte_t pb_rise;
    pced_byte_t pb_fall;
    pced_byte_t pb_flag;
    logic master_en;
    pced_byte_t irq_stat;
    pced_byte_t irq_mask;
    pced_byte_t rdata;
    logic summary;
    logic request;
    logic wake;
    logic irq;
  } pced_state_s;

  pced_state_s state_reg;
  pced_state_s state_next;

  logic [7:0] a_rise;
  logic [7:0] a_fall;
  logic [7:0] b_rise;
  logic [7:0] b_fall;

  pced_edge_sync #(
    .WIDTH(8)
  ) u_sync_a (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_async(port_a_pin),
    .rise_pulse(a_rise),
    .fall_pulse(a_fall)
  );

  pced_edge_sync #(
    .WIDTH(8)
  ) u_sync_b (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_async(port_b_pin),
    .rise_pulse(b_rise),
    .fall_pulse(b_fall)
  );

  // Edges that pass their enables, limited to implemented pins
  function automatic pced_byte_t armed_edges(
    input pced_byte_t rise,
    input pced_byte_t fall,
    input pced_byte_t rise_en,
    input pced_byte_t fall_en,
    input pced_byte_t impl
  );
    armed_edges = ((rise & rise_en) | (fall & fall_en)) & impl; // RQ3
  endfunction

  // Software may only clear; a new edge in the same cycle wins
  function automatic pced_byte_t flag_update(
    input pced_byte_t cur,
    input pced_byte_t hits,
    input logic wr,
    input pced_byte_t wdata,
    input pced_byte_t impl
  );
    pced_byte_t kept;
    kept = wr ? (cur & wdata) : cur; // RQ4
    flag_update = (kept | hits) & impl; // RQ9
  endfunction

  logic [7:0] a_hits;
  logic [7:0] b_hits;
  logic any_flag;
  logic any_hit;

  always_comb begin
    a_hits = armed_edges(a_rise, a_fall, state_reg.pa_rise, state_reg.pa_fall,
      `PCED_PA_MASK); // RQ7
    b_hits = armed_edges(b_rise, b_fall, state_reg.pb_rise, state_reg.pb_fall,
      `PCED_PB_MASK);
    any_hit = |{a_hits, b_hits};
    state_next = state_reg;

    // Enable registers; unimplemented bits never store
    if (reg_write) begin
      case (reg_addr)
        `PCED_ADDR_PA_RISE: state_next.pa_rise = reg_wdata & `PCED_PA_MASK; // RQ7
        `PCED_ADDR_PA_FALL: state_next.pa_fall = reg_wdata & `PCED_PA_MASK; // RQ7
        `PCED_ADDR_PB_RISE: state_next.pb_rise = reg_wdata & `PCED_PB_MASK; // RQ5
        `PCED_ADDR_PB_FALL: state_next.pb_fall = reg_wdata & `PCED_PB_MASK; // RQ1
        `PCED_ADDR_CTRL: state_next.master_en = reg_wdata[`PCED_CTRL_MASTER_BIT];
        `PCED_ADDR_IRQ_MASK: state_next.irq_mask = reg_wdata & `PCED_IRQ_MASK_BITS;
        default: ;
      endcase
    end

    // Flags set whatever the master enable says
    state_next.pa_flag = flag_update(state_reg.pa_flag, a_hits,
      reg_write && reg_addr == `PCED_ADDR_PA_FLAG, reg_wdata, `PCED_PA_MASK); // RQ8
    state_next.pb_flag = flag_update(state_reg.pb_flag, b_hits,
      reg_write && reg_addr == `PCED_ADDR_PB_FLAG, reg_wdata, `PCED_PB_MASK); // RQ2

    // Summary mirrors the OR of all flags
    any_flag = |{state_next.pa_flag, state_next.pb_flag};
    state_next.summary = any_flag; // RQ2
    state_next.request = any_flag & state_next.master_en; // RQ8
    // Wake only while asleep; flags are already updated by then
    state_next.wake = any_flag & state_next.master_en & sleep_active; // RQ10

    // Sticky events, write one to clear, set wins
    if (reg_write && reg_addr == `PCED_ADDR_IRQ_STAT) begin
      state_next.irq_stat = state_reg.irq_stat & ~reg_wdata;
    end
    if (any_hit) begin
      state_next.irq_stat[`PCED_IRQ_CHANGE_BIT] = 1'b1;
    end
    if (any_hit && state_reg.master_en && sleep_active) begin
      state_next.irq_stat[`PCED_IRQ_WAKE_BIT] = 1'b1; // RQ10
    end
    state_next.irq = |(state_next.irq_stat & state_next.irq_mask);

    // Read data stand one cycle after the strobe
    state_next.rdata = `PCED_RESET_BYTE;
    if (reg_read) begin
      case (reg_addr)
        `PCED_ADDR_PA_RISE: state_next.rdata = state_reg.pa_rise;
        `PCED_ADDR_PA_FALL: state_next.rdata = state_reg.pa_fall;
        `PCED_ADDR_PA_FLAG: state_next.rdata = state_reg.pa_flag;
        `PCED_ADDR_PB_RISE: state_next.rdata = state_reg.pb_rise; // RQ5
        `PCED_ADDR_PB_FALL: state_next.rdata = state_reg.pb_fall; // RQ5
        `PCED_ADDR_PB_FLAG: state_next.rdata = state_reg.pb_flag; // RQ5
        `PCED_ADDR_CTRL: begin
          state_next.rdata[`PCED_CTRL_MASTER_BIT] = state_reg.master_en;
          state_next.rdata[`PCED_CTRL_SUMMARY_BIT] = state_reg.summary;
        end
        `PCED_ADDR_IRQ_STAT: state_next.rdata = state_reg.irq_stat;
        `PCED_ADDR_IRQ_MASK: state_next.rdata = state_reg.irq_mask;
        default: state_next.rdata = `PCED_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0; // RQ6
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign change_irq_summary = state_reg.summary;
  assign change_irq_request = state_reg.request;
  assign wake_request = state_reg.wake;
  assign irq = state_reg.irq;
endmodule

// file: verif/pced_pin_driver.sv
`timescale 1ns/100ps
module pced_pin_driver (
  // Clock
  input wire logic ref_clk,
  // Wanted levels, pins
  input wire logic [7:0] a_want,
  input wire logic [7:0] b_want,
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin
);
  // Low at start, so reset sees no false edge
  initial port_a_pin = 8'h00;
  initial port_b_pin = 8'h00;
  // Moves on the rising edge itself, after the sync flops have sampled
  always @(posedge ref_clk) begin
    port_a_pin <= a_want;
    port_b_pin <= b_want;
  end
endmodule

// file: verif/pced_checker.sv
`timescale 1ns/100ps
module pced_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire pced_pkg::pced_addr_t reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire pced_pkg::pced_byte_t reg_rdata,
  // Pins and outputs
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic sleep_active,
  input wire logic change_irq_summary,
  input wire logic change_irq_request,
  input wire logic wake_request,
  input wire logic irq
);
  import pced_pkg::*;
  // Implemented pins only
  wire [9:0] used = {port_a_pin[5:0], port_b_pin[7:4]};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_request_gated: assert property (change_irq_request |-> change_irq_summary)
    else $error("request without summary");
  a_wake_needs_sleep: assert property (
    wake_request |-> change_irq_request && $past(sleep_active)) else $error("bad wake");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("rdata not idle");
  a_quiet_after_reset: assert property (
    $past(reset) |-> !irq && !change_irq_summary) else $error("output after reset");
  a_pb_low_zero: assert property ($past(reg_read) && $past(reg_addr) inside {4'h3, 4'h4, 4'h5}
    |-> reg_rdata[3:0] == 4'h0) else $error("port b low bits set");
  a_pa_top_zero: assert property ($past(reg_read) && $past(reg_addr) <= 4'h2
    |-> reg_rdata[7:6] == 2'h0) else $error("port a top bits set");
  a_flag_from_pin: assert property ($rose(change_irq_summary)
    |-> $past(used, 2) != $past(used, 5)) else $error("flag without pin edge");
  a_summary_clear: assert property ($fell(change_irq_summary)
    |-> $past(reg_write) && $past(reg_addr) inside {4'h2, 4'h5}) else $error("flag lost");
  a_irq_cause: assert property ($rose(irq) |-> $past(reg_write) || $past(reg_write, 2)
    || $past(used, 2) != $past(used, 5)) else $error("irq without cause");
endmodule
bind pced_pin_change pced_checker u_chk (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .port_a_pin(port_a_pin), .port_b_pin(port_b_pin), .sleep_active(sleep_active),
  .change_irq_summary(change_irq_summary), .change_irq_request(change_irq_request),
  .wake_request(wake_request), .irq(irq));

// file: verif/pced_pin_change_test.sv
`timescale 1ns/100ps
module pced_pin_change_test;
  import pced_pkg::*;
  logic ref_clk = '0, reset = '1, reg_write = '0, reg_read = '0, sleep_active = '0;
  logic change_irq_summary, change_irq_request, wake_request, irq;
  pced_addr_t reg_addr = '0;
  pced_byte_t reg_wdata = '0, a_want = '0, b_want = '0, reg_rdata;
  logic [7:0] port_a_pin, port_b_pin;
  int fail_count = 0, num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  pced_pin_driver u_pins (.*);
  pced_pin_change u_dut (.*);
  task automatic chk(string n, pced_byte_t s, pced_byte_t e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(pced_addr_t a, pced_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge ref_clk);
    reg_write <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(pced_addr_t a, pced_byte_t e);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge ref_clk);
  endtask
  task automatic outs(pced_byte_t e);
    #1 chk("outs", {4'h0, change_irq_summary, change_irq_request, wake_request, irq}, e);
    // Back on the edge so the next strobe starts just after it
    @(posedge ref_clk);
  endtask
  // Eight edges cover the two-flop sync plus flag latency
  task automatic pins(pced_byte_t a, pced_byte_t b);
    a_want <= a;
    b_want <= b;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic t_regs;
    pced_byte_t exp[6] = '{8'h3F, 8'h3F, 8'h00, 8'hF0, 8'hF0, 8'h00};
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    for (int i = 0; i < 6; i++) wr(4'(i), 8'hFF);
    wr(4'h9, 8'hFF);
    for (int i = 0; i < 6; i++) rd(4'(i), exp[i]);
    rd(4'h9, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_edges;
    pins(8'hFF, 8'hFF);
    rd(4'h2, 8'h3F);
    rd(4'h5, 8'hF0);
    rd(4'h6, 8'h01);
    outs(8'h08);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h0F);
    rd(4'h5, 8'h00);
    outs(8'h00);
    wr(4'h8, 8'h01);
    outs(8'h01);
    wr(4'h7, 8'h01);
    outs(8'h00);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h00);
    pins(8'h00, 8'h00);
    rd(4'h2, 8'h3F);
    rd(4'h5, 8'hF0);
    wr(4'h2, 8'h00);
    wr(4'h5, 8'h00);
    pins(8'hFF, 8'hFF);
    outs(8'h01);
    $display("test edges done");
  endtask
  task automatic t_wake;
    wr(4'h7, 8'h03);
    wr(4'h6, 8'hFF);
    sleep_active <= 1'h1;
    pins(8'h00, 8'h00);
    outs(8'h0F);
    rd(4'h6, 8'h09);
    rd(4'h7, 8'h03);
    sleep_active <= 1'h0;
    repeat (2) @(posedge ref_clk);
    outs(8'h0D);
    $display("test wake done");
  endtask
  // Clear write lands on the very edge that sets the flag
  task automatic t_race;
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    a_want <= 8'h01;
    repeat (3) @(posedge ref_clk);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h01);
    $display("test race done");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    t_regs();
    t_edges();
    t_wake();
    t_race();
    tally_and_finish();
  end
  // Far beyond the roughly 150 cycles the tests need
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
endmodule
